// >>> core/cai_pkg.sv
// Purpose: shared constants for the channel alarm interrupt block
// Assumes: eight channels, 8-bit registers, word-aligned bus slots
// Notes:   register indexes are word offsets; byte address = 4 * index
`default_nettype none

package cai_pkg;

    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int unsigned NCH = 8;
    localparam int unsigned DW  = 8;
    localparam int unsigned AW  = 10;
    localparam int unsigned SW  = NCH * 7;

    // ------------------------------------------------------------------
    // alarm bit positions, shared by live, change and enable registers
    // ------------------------------------------------------------------
    localparam int unsigned BIT_DRV  = 6;
    localparam int unsigned BIT_FIFO = 5;
    localparam int unsigned BIT_CV   = 4;
    localparam int unsigned BIT_AIS  = 2;
    localparam int unsigned BIT_LOS  = 1;
    localparam int unsigned BIT_PAT  = 0;
    localparam logic [7:0]  ALARM_MASK = 8'h77;

    // ------------------------------------------------------------------
    // register indexes
    // ------------------------------------------------------------------
    localparam logic [3:0] SUB_IRQ_EN     = 4'h4;
    localparam logic [3:0] SUB_LIVE       = 4'h5;
    localparam logic [3:0] SUB_CHG        = 4'h6;
    localparam logic [7:0] CH_SPAN        = 8'h80;
    localparam logic [7:0] IDX_GCTL       = 8'h80;
    localparam logic [7:0] IDX_GCTL_ALIAS = 8'hE0;
    localparam logic [7:0] IDX_GSEL       = 8'h81;
    localparam logic [7:0] IDX_SUM_STS    = 8'h90;
    localparam logic [7:0] IDX_SUM_MASK   = 8'h91;

    // ------------------------------------------------------------------
    // global fields and reset values
    // ------------------------------------------------------------------
    localparam int unsigned GIE_BIT     = 1;
    localparam int unsigned OVF_SEL_BIT = 7;
    localparam logic [7:0]  GCTL_WMASK  = 8'hFB;
    localparam logic [7:0]  REG_RST     = 8'h00;

    typedef enum logic [1:0] {
        CAI_BUS_IDLE = 2'b01,
        CAI_BUS_ACK  = 2'b10
    } cai_bus_t;

endpackage

`default_nettype wire

// >>> core/cai_sync.sv
// Purpose: two-stage synchroniser for alarm detector levels
// Assumes: inputs are levels from other clock domains
// Notes:   stage one feeds stage two only
`timescale 1ns/10ps
`default_nettype none

module cai_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         mclk_i,
    input  wire logic         resetn_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;

endmodule

`default_nettype wire

// >>> core/cai_chan.sv
// Purpose: one channel: live alarms, change latch, interrupt enables
// Assumes: alarm inputs already synchronised to mclk_i
// Notes:   change set wins over a clearing read in the same cycle
`timescale 1ns/10ps
`default_nettype none

module cai_chan (
    input  wire logic       mclk_i,
    input  wire logic       resetn_i,
    input  wire logic       drv_i,
    input  wire logic       fifo_i,
    input  wire logic       viol_i,
    input  wire logic       ovf_i,
    input  wire logic       ais_i,
    input  wire logic       los_i,
    input  wire logic       pat_i,
    input  wire logic       ovf_sel_i,
    input  wire logic       en_we_i,
    input  wire logic [7:0] en_wdata_i,
    input  wire logic       clr_i,
    input  wire logic [7:0] clr_mask_i,
    output logic      [7:0] live_o,
    output logic      [7:0] chg_o,
    output logic      [7:0] en_o,
    output logic            pend_o
);

    logic [7:0] live_d;
    logic [7:0] live_q;
    logic [7:0] chg_q;
    logic [7:0] en_q;

    // ------------------------------------------------------------------
    // live status
    // ------------------------------------------------------------------
    always_comb begin
        live_d = 8'h00;
        // [R01] [R02] alarm bit placement
        live_d[cai_pkg::BIT_DRV]  = drv_i;
        live_d[cai_pkg::BIT_FIFO] = fifo_i;
        // [R03] [R04] violation or overflow
        live_d[cai_pkg::BIT_CV]   = ovf_sel_i ? ovf_i : viol_i;
        // [R05] [R06] [R07] receive alarm placement
        live_d[cai_pkg::BIT_AIS]  = ais_i;
        live_d[cai_pkg::BIT_LOS]  = los_i;
        live_d[cai_pkg::BIT_PAT]  = pat_i;
    end

    // [R08] updates ignore enables
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            live_q <= cai_pkg::REG_RST;
        end else begin
            live_q <= live_d;
        end
    end

    // [R11] [R19] latch changes, set wins
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            chg_q <= cai_pkg::REG_RST;
        end else begin
            chg_q <= (chg_q & ~(clr_i ? clr_mask_i : 8'h00))
                   | ((live_d ^ live_q) & cai_pkg::ALARM_MASK);
        end
    end

    // [R16] [R14] enables, unused bits zero
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            en_q <= cai_pkg::REG_RST;
        end else if (en_we_i) begin
            en_q <= en_wdata_i & cai_pkg::ALARM_MASK;
        end
    end

    assign live_o = live_q;
    assign chg_o  = chg_q;
    assign en_o   = en_q;
    assign pend_o = |(chg_q & en_q);

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_drv_live: assert property ( // [R01]
        @(posedge mclk_i) disable iff (!resetn_i)
        ##1 live_q[cai_pkg::BIT_DRV] == $past(drv_i))
        else $error("driver fault bit does not follow its input");

    a_cv_select: assert property ( // [R04]
        @(posedge mclk_i) disable iff (!resetn_i)
        ovf_sel_i |=> live_q[cai_pkg::BIT_CV] == $past(ovf_i))
        else $error("overflow select not honoured");

    a_change_set: assert property ( // [R19]
        @(posedge mclk_i) disable iff (!resetn_i)
        ##1 ((live_q ^ $past(live_q)) & ~chg_q) == 8'h00)
        else $error("alarm change not latched");

    a_unused_zero: assert property ( // [R14]
        @(posedge mclk_i) disable iff (!resetn_i)
        ((live_q | chg_q | en_q) & ~cai_pkg::ALARM_MASK) == 8'h00)
        else $error("unused bit set");

endmodule

`default_nettype wire

// >>> core/cai_top.sv
// Purpose: eight-channel alarm status, change latch and interrupt
// Assumes: Avalon-MM slave, one cycle of waitrequest per access
// Notes:   alarm inputs are asynchronous levels, synchronised here
// Functional notes
// [R01] driver fault shown on live bit 6
// [R02] fifo pointers within three bits, bit 5
// [R03] bit 4 shows code violations by default
// [R04] global select shows counter overflow instead
// [R05] all-ones alarm shown on bit 2
// [R06] signal loss shown on bit 1
// [R07] pattern detect shown on bit 0
// [R08] live bits update whatever the enables
// [R09] no interrupt without per-alarm enable
// [R10] no interrupt without global enable
// [R11] change register latches each alarm change
// [R12] enabled latched change raises the interrupt
// [R13] reading change register clears its bits
// [R14] bits 7 and 3 unused
// [R15] eight channels, stride 0x10
// [R16] enable register bits mask or enable alarms
// [R17] global enable bit 1 gates all channels
// [R18] interrupt holds until enabled changes clear
// [R19] change during clearing read stays latched
`timescale 1ns/10ps
`default_nettype none

module cai_top (
    input  wire logic                    mclk_i,
    input  wire logic                    resetn_i,
    input  wire logic [cai_pkg::AW-1:0]  avs_address_i,
    input  wire logic                    avs_read_i,
    input  wire logic                    avs_write_i,
    input  wire logic [31:0]             avs_writedata_i,
    input  wire logic [3:0]              avs_byteenable_i,
    output logic      [31:0]             avs_readdata_o,
    output logic                         avs_waitrequest_o,
    input  wire logic [cai_pkg::NCH-1:0] driver_fault_monitor_i,
    input  wire logic [cai_pkg::NCH-1:0] fifo_limit_flag_i,
    input  wire logic [cai_pkg::NCH-1:0] code_violation_i,
    input  wire logic [cai_pkg::NCH-1:0] counter_overflow_i,
    input  wire logic [cai_pkg::NCH-1:0] all_ones_alarm_i,
    input  wire logic [cai_pkg::NCH-1:0] receive_signal_loss_i,
    input  wire logic [cai_pkg::NCH-1:0] pseudo_random_pattern_detect_i,
    output logic                         irq_o
);

    localparam int unsigned N = cai_pkg::NCH;

    cai_pkg::cai_bus_t bus_q;
    logic              waitreq_q;
    logic [31:0]       rdata_q;
    logic              irq_q;
    logic [7:0]        gctl_q;
    logic [7:0]        gsel_q;
    logic [7:0]        sum_sts_q;
    logic [7:0]        sum_mask_q;
    logic [N-1:0]      pend_q;

    logic [cai_pkg::SW-1:0] raw_s;
    logic [N-1:0]           drv_s;
    logic [N-1:0]           fifo_s;
    logic [N-1:0]           viol_s;
    logic [N-1:0]           ovf_s;
    logic [N-1:0]           ais_s;
    logic [N-1:0]           los_s;
    logic [N-1:0]           pat_s;

    logic [7:0]   live_w [N];
    logic [7:0]   chg_w  [N];
    logic [7:0]   en_w   [N];
    logic [N-1:0] pend_w;
    logic [N-1:0] en_we_w;
    logic [N-1:0] clr_w;

    logic       start_w;
    logic       rd_fire;
    logic       wr_fire;
    logic       wr_lane0;
    logic [7:0] idx_w;
    logic       ch_hit;
    logic [2:0] ch_w;
    logic [3:0] sub_w;
    logic [7:0] rd_d;
    logic [7:0] wdat_w;
    logic       gie_w;
    logic       ovf_sel_w;
    logic [N-1:0] new_ev_w;
    logic       irq_d;

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    cai_sync #(
        .W (cai_pkg::SW)
    ) u_sync (
        .mclk_i   (mclk_i),
        .resetn_i (resetn_i),
        .d_i      ({driver_fault_monitor_i, fifo_limit_flag_i,
                    code_violation_i, counter_overflow_i,
                    all_ones_alarm_i, receive_signal_loss_i,
                    pseudo_random_pattern_detect_i}),
        .q_o      (raw_s)
    );

    assign {drv_s, fifo_s, viol_s, ovf_s, ais_s, los_s, pat_s} = raw_s;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    assign idx_w    = avs_address_i[cai_pkg::AW-1:2];
    assign ch_hit   = (idx_w < cai_pkg::CH_SPAN);
    assign ch_w     = idx_w[6:4];
    assign sub_w    = idx_w[3:0];
    assign start_w  = (avs_read_i | avs_write_i) & waitreq_q;
    assign rd_fire  = avs_read_i & ~waitreq_q;
    assign wr_fire  = avs_write_i & ~waitreq_q;
    assign wr_lane0 = wr_fire & avs_byteenable_i[0];
    assign wdat_w   = avs_writedata_i[7:0];

    // ------------------------------------------------------------------
    // channels
    // ------------------------------------------------------------------
    // [R15] replicated channels
    for (genvar c = 0; c < N; c++) begin : g_ch
        assign en_we_w[c] = wr_lane0 & ch_hit & (ch_w == 3'(c))
                          & (sub_w == cai_pkg::SUB_IRQ_EN);
        // [R13] clear on completed read
        assign clr_w[c]   = rd_fire & ch_hit & (ch_w == 3'(c))
                          & (sub_w == cai_pkg::SUB_CHG);

        cai_chan u_chan (
            .mclk_i     (mclk_i),
            .resetn_i   (resetn_i),
            .drv_i      (drv_s[c]),
            .fifo_i     (fifo_s[c]),
            .viol_i     (viol_s[c]),
            .ovf_i      (ovf_s[c]),
            .ais_i      (ais_s[c]),
            .los_i      (los_s[c]),
            .pat_i      (pat_s[c]),
            .ovf_sel_i  (ovf_sel_w),
            .en_we_i    (en_we_w[c]),
            .en_wdata_i (wdat_w),
            .clr_i      (clr_w[c]),
            .clr_mask_i (rdata_q[7:0]),
            .live_o     (live_w[c]),
            .chg_o      (chg_w[c]),
            .en_o       (en_w[c]),
            .pend_o     (pend_w[c])
        );
    end

    // ------------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------------
    // one waitrequest-low cycle per access, so a clearing read
    // can never complete twice
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bus_q     <= cai_pkg::CAI_BUS_IDLE;
            waitreq_q <= 1'b1;
        end else begin
            case (bus_q)
                cai_pkg::CAI_BUS_IDLE: begin
                    if (start_w) begin
                        bus_q     <= cai_pkg::CAI_BUS_ACK;
                        waitreq_q <= 1'b0;
                    end
                end
                cai_pkg::CAI_BUS_ACK: begin
                    bus_q     <= cai_pkg::CAI_BUS_IDLE;
                    waitreq_q <= 1'b1;
                end
                default: begin
                    bus_q     <= cai_pkg::CAI_BUS_IDLE;
                    waitreq_q <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    always_comb begin
        rd_d = 8'h00;
        if (ch_hit && sub_w == cai_pkg::SUB_IRQ_EN) begin
            rd_d = en_w[ch_w];
        end else if (ch_hit && sub_w == cai_pkg::SUB_LIVE) begin
            rd_d = live_w[ch_w];
        end else if (ch_hit && sub_w == cai_pkg::SUB_CHG) begin
            rd_d = chg_w[ch_w];
        end else if (idx_w == cai_pkg::IDX_GCTL
                     || idx_w == cai_pkg::IDX_GCTL_ALIAS) begin
            rd_d = gctl_q;
        end else if (idx_w == cai_pkg::IDX_GSEL) begin
            rd_d = gsel_q;
        end else if (idx_w == cai_pkg::IDX_SUM_STS) begin
            rd_d = sum_sts_q;
        end else if (idx_w == cai_pkg::IDX_SUM_MASK) begin
            rd_d = sum_mask_q;
        end
    end

    // sampled at the start edge; the same byte is the clear mask,
    // so a bit that sets after sampling is not lost
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (start_w && avs_read_i) begin
            rdata_q <= {24'h00_0000, rd_d};
        end
    end

    // ------------------------------------------------------------------
    // global registers
    // ------------------------------------------------------------------
    // [R10] [R17] global enable, both indexes
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            gctl_q <= cai_pkg::REG_RST;
        end else if (wr_lane0 && (idx_w == cai_pkg::IDX_GCTL
                     || idx_w == cai_pkg::IDX_GCTL_ALIAS)) begin
            gctl_q <= wdat_w & cai_pkg::GCTL_WMASK;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            gsel_q <= cai_pkg::REG_RST;
        end else if (wr_lane0 && idx_w == cai_pkg::IDX_GSEL) begin
            gsel_q <= wdat_w;
        end
    end

    assign gie_w     = gctl_q[cai_pkg::GIE_BIT];
    assign ovf_sel_w = gsel_q[cai_pkg::OVF_SEL_BIT];

    // ------------------------------------------------------------------
    // channel summary status and mask
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pend_q <= '0;
        end else begin
            pend_q <= pend_w;
        end
    end

    assign new_ev_w = pend_w & ~pend_q;

    // write one to clear; a new event in the same cycle wins
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sum_sts_q <= cai_pkg::REG_RST;
        end else begin
            sum_sts_q <= (sum_sts_q
                         & ~((wr_lane0 && idx_w == cai_pkg::IDX_SUM_STS)
                             ? wdat_w : 8'h00))
                       | new_ev_w;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sum_mask_q <= cai_pkg::REG_RST;
        end else if (wr_lane0 && idx_w == cai_pkg::IDX_SUM_MASK) begin
            sum_mask_q <= wdat_w;
        end
    end

    // ------------------------------------------------------------------
    // interrupt
    // ------------------------------------------------------------------
    // [R09] [R12] [R18] enabled changes, global gate
    assign irq_d = gie_w & ((|pend_w) | (|(sum_sts_q & sum_mask_q)));

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    assign irq_o             = irq_q;
    assign avs_readdata_o    = rdata_q;
    assign avs_waitrequest_o = waitreq_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    logic       clr_fire_q;
    logic [2:0] clr_ch_q;
    logic [7:0] clr_mask_q;
    logic [7:0] clr_live_q;

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            clr_fire_q <= 1'b0;
            clr_ch_q   <= 3'h0;
            clr_mask_q <= 8'h00;
            clr_live_q <= 8'h00;
        end else begin
            clr_fire_q <= |clr_w;
            clr_ch_q   <= ch_w;
            clr_mask_q <= rdata_q[7:0];
            clr_live_q <= live_w[ch_w];
        end
    end

    a_read_clear: assert property ( // [R13]
        @(posedge mclk_i) disable iff (!resetn_i)
        clr_fire_q |-> (chg_w[clr_ch_q] & clr_mask_q
                        & ~(live_w[clr_ch_q] ^ clr_live_q)) == 8'h00)
        else $error("change bits not cleared by read");

    a_irq_global: assert property ( // [R10]
        @(posedge mclk_i) disable iff (!resetn_i)
        !gie_w |=> !irq_q)
        else $error("interrupt without global enable");

    a_irq_raise: assert property ( // [R12]
        @(posedge mclk_i) disable iff (!resetn_i)
        (gie_w && pend_w != '0) |=> irq_q)
        else $error("enabled change did not interrupt");

    a_irq_drop: assert property ( // [R18]
        @(posedge mclk_i) disable iff (!resetn_i)
        (pend_w == '0 && (sum_sts_q & sum_mask_q) == 8'h00) |=> !irq_q)
        else $error("interrupt held with nothing pending");

    a_irq_enable: assert property ( // [R09]
        @(posedge mclk_i) disable iff (!resetn_i)
        (en_w[0] == 8'h00 && en_w[1] == 8'h00 && en_w[2] == 8'h00
         && en_w[3] == 8'h00 && en_w[4] == 8'h00 && en_w[5] == 8'h00
         && en_w[6] == 8'h00 && en_w[7] == 8'h00
         && sum_mask_q == 8'h00) |=> !irq_q)
        else $error("interrupt with every alarm masked");

    a_wait_pulse: assert property (
        @(posedge mclk_i) disable iff (!resetn_i)
        start_w |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("waitrequest not a single low cycle");

    a_stride_read: assert property ( // [R15]
        @(posedge mclk_i) disable iff (!resetn_i)
        (start_w && avs_read_i && ch_hit && sub_w == cai_pkg::SUB_LIVE)
        |=> avs_readdata_o[7:0] == $past(live_w[ch_w]))
        else $error("live read returned wrong channel");

    a_global_alias: assert property ( // [R17]
        @(posedge mclk_i) disable iff (!resetn_i)
        (wr_lane0 && idx_w == cai_pkg::IDX_GCTL_ALIAS)
        |=> gie_w == $past(wdat_w[cai_pkg::GIE_BIT]))
        else $error("alias write missed global enable");

    c_read_clear: cover property (
        @(posedge mclk_i) disable iff (!resetn_i)
        clr_fire_q && clr_mask_q != 8'h00);

    c_irq_rise: cover property (
        @(posedge mclk_i) disable iff (!resetn_i)
        !irq_q ##1 irq_q);

    c_set_on_clear: cover property (
        @(posedge mclk_i) disable iff (!resetn_i)
        clr_fire_q && (live_w[clr_ch_q] ^ clr_live_q) != 8'h00);

endmodule

`default_nettype wire

// >>> verif/cai_tb.sv
// Purpose: self-checking bench for the channel alarm interrupt block
// Assumes: one waitrequest cycle per access, alarm levels held steady
// Notes:   six-cycle waits cover two sync flops plus the live register
`timescale 1ns/10ps
`default_nettype none

module channel_alarm_interrupt_status_tb;
    logic        mclk_i          = 1'b0;
    logic        resetn_i        = 1'b0;
    logic [9:0]  avs_address_i   = 10'h000;
    logic        avs_read_i      = 1'b0;
    logic        avs_write_i     = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0000_0000;
    logic [3:0]  avs_byteenable_i = 4'hF;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        irq_o;
    // order: drv, fifo, viol, ovf, all-ones, loss, pattern
    logic [7:0]  alm [7]         = '{default: 8'h00};
    int          pos [7]         = '{6, 5, 4, 4, 2, 1, 0};
    int          failures        = 0;
    int          n_tests         = 0;
    int          cycles          = 0;

    always #2.5 mclk_i = ~mclk_i;

    cai_top dut (
        .mclk_i(mclk_i), .resetn_i(resetn_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .driver_fault_monitor_i(alm[0]), .fifo_limit_flag_i(alm[1]),
        .code_violation_i(alm[2]), .counter_overflow_i(alm[3]),
        .all_ones_alarm_i(alm[4]), .receive_signal_loss_i(alm[5]),
        .pseudo_random_pattern_detect_i(alm[6]), .irq_o(irq_o)
    );

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic wrap_up();
        if (failures == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // hang guard: whole run is a few hundred cycles
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            wrap_up();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            failures++;
        end
    endtask

    // request held until waitrequest is sampled low at a rising edge
    task automatic acc(input logic wr, input logic [7:0] idx,
                       input logic [7:0] wd, output logic [31:0] rd);
        @(posedge mclk_i);
        avs_address_i   <= {idx, 2'b00};
        avs_read_i      <= ~wr;
        avs_write_i     <= wr;
        avs_writedata_i <= {24'h00_0000, wd};
        do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [31:0] rd;
        acc(1'b1, idx, wd, rd);
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] rd;
        acc(1'b0, idx, 8'h00, rd);
        chk($sformatf("reg %h", idx), exp, rd);
    endtask

    task automatic irqchk(input logic exp);
        chk("irq", {31'h0, exp}, {31'h0, irq_o});
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        rdchk(8'h05, 32'h00);
        rdchk(8'h06, 32'h00);
        rdchk(8'h04, 32'h00);
        rdchk(8'h80, 32'h00);
        rdchk(8'h07, 32'h00);
    endtask

    task automatic t_bits();
        for (int k = 0; k < 7; k++) begin
            if (k == 3) continue;
            @(posedge mclk_i);
            alm[k][7] <= 1'b1;
            cyc(6);
            rdchk(8'h75, 32'h1 << pos[k]);
            alm[k][7] <= 1'b0;
            cyc(6);
            rdchk(8'h75, 32'h00);
        end
        rdchk(8'h76, 32'h77);
        rdchk(8'h76, 32'h00);
        irqchk(1'b0);
    endtask

    task automatic t_ovf();
        wr(8'h81, 8'h80);
        @(posedge mclk_i);
        alm[3][7] <= 1'b1;
        cyc(6);
        rdchk(8'h75, 32'h10);
        rdchk(8'h76, 32'h10);
        alm[3][7] <= 1'b0;
        cyc(6);
        rdchk(8'h76, 32'h10);
        wr(8'h81, 8'h00);
    endtask

    task automatic t_mask();
        wr(8'h04, 8'hFF);
        rdchk(8'h04, 32'h77);
        @(posedge mclk_i);
        alm[5][0] <= 1'b1;
        cyc(6);
        irqchk(1'b0);
        rdchk(8'h05, 32'h02);
        wr(8'h80, 8'h02);
        cyc(3);
        irqchk(1'b1);
        rdchk(8'hE0, 32'h02);
        rdchk(8'h06, 32'h02);
        cyc(3);
        irqchk(1'b0);
        wr(8'h04, 8'h01);
        alm[5][0] <= 1'b0;
        cyc(6);
        irqchk(1'b0);
        rdchk(8'h06, 32'h02);
    endtask

    // summary status and mask, lane-0 byte enable
    task automatic t_sum();
        rdchk(8'h90, 32'h01);
        avs_byteenable_i <= 4'hE;
        wr(8'h91, 8'h01);
        avs_byteenable_i <= 4'hF;
        rdchk(8'h91, 32'h00);
        wr(8'h91, 8'h01);
        cyc(3);
        irqchk(1'b1);
        wr(8'h90, 8'h01);
        cyc(3);
        irqchk(1'b0);
        rdchk(8'h90, 32'h00);
        wr(8'h91, 8'h00);
    endtask

    initial begin
        repeat (8) @(posedge mclk_i);
        resetn_i <= 1'b1;
        @(posedge mclk_i);
        t_reset();
        t_bits();
        t_ovf();
        t_mask();
        t_sum();
        wrap_up();
    end
endmodule

`default_nettype wire
